/* common/spi_diag_pkg.sv */
// Constants and types for the SPI frame protocol and diagnosis block.
// Assumes 16-bit frames, MSB first, and a byte-wide register map.
package spi_diag_pkg;

    // ==========================================================
    // Frame geometry
    localparam int          FRAME_BITS     = 16;
    localparam int          BYTE_BITS      = 8;
    localparam int          CNT_W          = 5;
    localparam int          PHASE_W        = 3;
    localparam logic [4:0]  MIN_FRAME_BITS = 5'h10;
    localparam logic [2:0]  PHASE_ALIGNED  = 3'h0;

    // ==========================================================
    // Command field positions and codes
    localparam int          CMD_WRITE_BIT  = 15;
    localparam int          CMD_SECOND_BIT = 14;
    localparam int          ADDR_UP_HI     = 13;
    localparam int          ADDR_UP_LO     = 10;
    localparam int          ADDR_LO_HI     = 9;
    localparam int          ADDR_LO_LO     = 8;
    localparam int          DATA_HI        = 7;
    localparam logic [1:0]  TAIL_DIAG      = 2'h1;
    localparam logic [1:0]  TAIL_READ      = 2'h2;
    localparam logic [1:0]  LEAD_REPLY     = 2'h2;

    // ==========================================================
    // Standard diagnosis word layout
    localparam int          DG_UV          = 14;
    localparam int          DG_LOP         = 13;
    localparam int          DG_TER         = 10;
    localparam int          DG_OPEN_LOAD_OFF_FLAG       = 8;
    localparam logic [15:0] DIAG_RESET     = 16'h7800;
    localparam logic [1:0]  MODE_LIMP      = 2'h1;
    localparam logic [1:0]  MODE_ACTIVE    = 2'h2;
    localparam logic [1:0]  MODE_IDLE      = 2'h3;

    // ==========================================================
    // Register addresses (upper field, lower field)
    localparam logic [3:0]  AU_OUT   = 4'h0;
    localparam logic [3:0]  AU_MAP   = 4'h1;
    localparam logic [3:0]  AU_DIAG  = 4'h2;
    localparam logic [3:0]  AU_HWCR  = 4'h3;
    localparam logic [1:0]  AL_0     = 2'h0;
    localparam logic [1:0]  AL_1     = 2'h1;
    localparam logic [1:0]  AL_2     = 2'h2;

    // ==========================================================
    // Reset values and control bits
    localparam logic [7:0]  OUT_RST      = 8'h00;
    localparam logic [7:0]  MAP0_RST     = 8'h04;
    localparam logic [7:0]  MAP1_RST     = 8'h08;
    localparam logic [7:0]  IOL_RST      = 8'h00;
    localparam logic [7:0]  HWCR_RST     = 8'h00;
    localparam int          HWCR_ACT_BIT = 7;
    localparam int          HWCR_RST_BIT = 6;

    typedef enum logic [3:0] {
        RK_NONE, RK_OUT, RK_MAP0, RK_MAP1, RK_INPUT_STATUS_MONITOR,
        RK_IOL, RK_OSM, RK_HWCR, RK_OCL
    } reg_kind_type;

    typedef enum logic [1:0] {
        ST_FRESH = 2'b01,
        ST_RUN   = 2'b10
    } link_state_type;

    // Address decode shared by read and write paths
    function automatic reg_kind_type decode_addr(input logic [3:0] up,
                                                 input logic [1:0] lo);
        reg_kind_type k;
        k = RK_NONE;
        if (up == AU_OUT && lo == AL_0)  k = RK_OUT;
        if (up == AU_MAP && lo == AL_0)  k = RK_MAP0;
        if (up == AU_MAP && lo == AL_1)  k = RK_MAP1;
        if (up == AU_MAP && lo == AL_2)  k = RK_INPUT_STATUS_MONITOR;
        if (up == AU_DIAG && lo == AL_0) k = RK_IOL;
        if (up == AU_DIAG && lo == AL_1) k = RK_OSM;
        if (up == AU_HWCR && lo == AL_0) k = RK_HWCR;
        if (up == AU_HWCR && lo == AL_1) k = RK_OCL;
        return k;
    endfunction

endpackage

/* common/frame_if.sv */
// Carrier between the serial-clock link logic and the system-clock core.
// Link values are quasi-static once chip select has gone high.
`timescale 1ns/100ps
interface frame_if;
    logic [15:0] rx_word;
    logic [4:0]  bit_count;
    logic [2:0]  bit_phase;
    logic [15:0] resp_word;
    logic        link_clear;

    modport link (output rx_word, output bit_count, output bit_phase,
                  input resp_word, input link_clear);
    modport core (input rx_word, input bit_count, input bit_phase,
                  output resp_word, output link_clear);
endinterface

/* rtl/level_sync.sv */
// Two-stage synchroniser for a level from another clock domain.
// Assumes a synchronous active-low reset in the destination domain.
`timescale 1ns/100ps
module level_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    // First stage feeds only the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule

/* rtl/spi_link.sv */
// Serial-clock side: shifts in the command and shifts out the answer.
// Assumes sclk idles outside frames and link_clear is a clean flop output.
`timescale 1ns/100ps
module spi_link
    import spi_diag_pkg::*;
(
    input  wire logic sclk,
    input  wire logic si,
    frame_if.link     lnk,
    output logic      so_data
);

    logic [15:0] rx_reg;
    logic [15:0] rx_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [2:0]  phase_reg;
    logic [2:0]  phase_next;
    logic [4:0]  tx_cnt_reg;
    logic [4:0]  tx_cnt_next;
    logic        so_reg;
    logic        so_next;

    // ==========================================================
    // Receive on falling edge, count pulses
    always_comb begin
        rx_next    = {rx_reg[14:0], si};
        cnt_next   = (cnt_reg < MIN_FRAME_BITS) ? cnt_reg + 5'h01 : cnt_reg;
        phase_next = phase_reg + 3'h1;
    end

    always_ff @(negedge sclk or posedge lnk.link_clear) begin
        if (lnk.link_clear) begin
            rx_reg    <= 16'h0000;
            cnt_reg   <= 5'h00;
            phase_reg <= 3'h0;
        end else begin
            rx_reg    <= rx_next;
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
        end
    end

    // ==========================================================
    // Transmit on rising edge; past 16 bits pass input through
    always_comb begin
        tx_cnt_next = (tx_cnt_reg < MIN_FRAME_BITS) ? tx_cnt_reg + 5'h01
                                                    : tx_cnt_reg;
        if (tx_cnt_reg < MIN_FRAME_BITS) begin
            so_next = lnk.resp_word[4'(4'hf - tx_cnt_reg[3:0])];
        end else begin
            so_next = rx_reg[15];
        end
    end

    always_ff @(posedge sclk or posedge lnk.link_clear) begin
        if (lnk.link_clear) begin
            tx_cnt_reg <= 5'h00;
            so_reg     <= 1'b0;
        end else begin
            tx_cnt_reg <= tx_cnt_next;
            so_reg     <= so_next;
        end
    end

    assign lnk.rx_word   = rx_reg;
    assign lnk.bit_count = cnt_reg;
    assign lnk.bit_phase = phase_reg;
    assign so_data       = so_reg;

endmodule

/* rtl/spi_frame_protocol_diag.sv */
// SPI slave frame protocol, register map and standard diagnosis word.
// Assumes status inputs come from logic on sys_clk; SPI pins do not.
`timescale 1ns/100ps
module spi_frame_protocol_diag
    import spi_diag_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       si,
    output logic            so_data,
    output logic            so_oe_n,
    input  wire logic       supply_undervoltage_event,
    input  wire logic       logic_supply_low_event,
    input  wire logic [1:0] operating_mode,
    input  wire logic [7:0] channel_fault,
    input  wire logic [7:0] drain_below_threshold,
    input  wire logic [6:0] input_status,
    output logic [7:0]      out_enable,
    output logic [7:0]      map_in0,
    output logic [7:0]      map_in1,
    output logic [7:0]      diag_current_enable,
    output logic [7:0]      hw_config,
    output logic [7:0]      latch_clear
);
    import spi_diag_pkg::*;

    frame_if lnk ();

    logic           cs_sync;
    logic           cs_d_reg;
    logic           cs_d_next;
    logic           clr_reg;
    logic           clr_next;
    logic           oe_n_reg;
    logic           oe_n_next;
    logic [15:0]    resp_reg;
    logic [15:0]    resp_next;
    link_state_type state_reg;
    link_state_type state_next;
    logic           ter_reg;
    logic           ter_next;
    logic           uv_reg;
    logic           uv_next;
    logic           lop_reg;
    logic           lop_next;
    logic [1:0]     mode_reg;
    logic [1:0]     mode_next;
    logic           open_load_off_flag_reg;
    logic           open_load_off_flag_next;
    logic [7:0]     fault_reg;
    logic [7:0]     fault_next;
    logic [7:0]     out_reg;
    logic [7:0]     out_next;
    logic [7:0]     map0_reg;
    logic [7:0]     map0_next;
    logic [7:0]     map1_reg;
    logic [7:0]     map1_next;
    logic [7:0]     iol_reg;
    logic [7:0]     iol_next;
    logic [7:0]     hwcr_reg;
    logic [7:0]     hwcr_next;
    logic [7:0]     ocl_reg;
    logic [7:0]     ocl_next;

    // ==========================================================
    // Link side and chip-select crossing
    spi_link u_link (
        .sclk    (sclk),
        .si      (si),
        .lnk     (lnk.link),
        .so_data (so_data)
    );

    level_sync #(
        .RESET_VALUE (1'b1)
    ) u_cs_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (cs_n),
        .sync_out (cs_sync)
    );

    assign lnk.resp_word  = resp_reg;
    assign lnk.link_clear = clr_reg;

    // ==========================================================
    // Frame decode, register map and diagnosis flags
    always_comb begin
        logic         frame_end;
        logic         valid;
        logic         syntax_ok;
        logic         diag_reply;
        logic         soft_reset;
        logic [15:0]  w;
        logic [15:0]  diag_word;
        logic [7:0]   input_status_monitor_byte;
        logic [7:0]   rd_val;
        reg_kind_type kind;

        frame_end  = cs_sync & ~cs_d_reg;
        valid      = 1'b0;
        syntax_ok  = 1'b0;
        diag_reply = 1'b0;
        soft_reset = 1'b0;
        w          = lnk.rx_word;
        kind       = decode_addr(w[ADDR_UP_HI:ADDR_UP_LO],
                                 w[ADDR_LO_HI:ADDR_LO_LO]);
        rd_val     = 8'h00;
        input_status_monitor_byte  = 8'h00;
        diag_word  = 16'h0000;

        cs_d_next  = cs_sync;
        oe_n_next  = cs_sync;
        // Hold link in clear from frame end until next select
        clr_next   = frame_end ? 1'b1 : (cs_sync ? clr_reg : 1'b0);
        resp_next  = resp_reg;
        state_next = state_reg;
        ter_next   = ter_reg;
        uv_next    = uv_reg | supply_undervoltage_event;
        lop_next   = lop_reg | logic_supply_low_event;
        mode_next  = operating_mode;
        open_load_off_flag_next = |(~out_reg & iol_reg & drain_below_threshold);
        fault_next = (fault_reg & ~ocl_reg) | channel_fault;
        out_next   = out_reg;
        map0_next  = map0_reg;
        map1_next  = map1_reg;
        iol_next   = iol_reg;
        hwcr_next  = hwcr_reg;
        ocl_next   = 8'h00;

        if (frame_end) begin
            valid = (lnk.bit_count == MIN_FRAME_BITS) &&
                    (lnk.bit_phase == PHASE_ALIGNED);
            ter_next  = ~valid;
            input_status_monitor_byte = {~valid, input_status};
            diag_word = {1'b0, uv_reg, lop_reg, mode_reg, ~valid, 1'b0,
                         open_load_off_flag_reg, fault_reg};
            diag_reply = 1'b1;
            resp_next  = diag_word;
            if (valid && w[CMD_WRITE_BIT]) begin
                // Write frame: second bit must be 0, target writable
                syntax_ok = ~w[CMD_SECOND_BIT] &&
                            (kind == RK_OUT || kind == RK_MAP0 ||
                             kind == RK_MAP1 || kind == RK_IOL ||
                             kind == RK_HWCR || kind == RK_OCL);
                if (syntax_ok) begin
                    unique case (kind)
                        RK_OUT:  out_next  = w[DATA_HI:0];
                        RK_MAP0: map0_next = w[DATA_HI:0];
                        RK_MAP1: map1_next = w[DATA_HI:0];
                        RK_IOL:  iol_next  = w[DATA_HI:0];
                        RK_OCL:  ocl_next  = w[DATA_HI:0];
                        default: begin
                            hwcr_next  = w[DATA_HI:0] & ~(8'h01 << HWCR_RST_BIT);
                            soft_reset = w[HWCR_RST_BIT];
                        end
                    endcase
                end
            end else if (valid && w[1:0] != TAIL_DIAG) begin
                // Register read; undefined or malformed reads get diagnosis
                syntax_ok = w[CMD_SECOND_BIT] && (w[1:0] == TAIL_READ) &&
                            kind != RK_NONE && kind != RK_OCL;
                unique case (kind)
                    RK_OUT:  rd_val = out_reg;
                    RK_MAP0: rd_val = map0_reg;
                    RK_MAP1: rd_val = map1_reg;
                    RK_INPUT_STATUS_MONITOR: rd_val = input_status_monitor_byte;
                    RK_IOL:  rd_val = iol_reg;
                    RK_OSM:  rd_val = drain_below_threshold;
                    RK_HWCR: rd_val = hwcr_reg;
                    default: rd_val = 8'h00;
                endcase
                if (syntax_ok) begin
                    resp_next  = {LEAD_REPLY, w[ADDR_UP_HI:ADDR_LO_LO],
                                  rd_val};
                    diag_reply = 1'b0;
                end
            end
            // First answer after reset carries INPUT_STATUS_MONITOR with error flag
            if (state_reg == ST_FRESH) begin
                resp_next  = {LEAD_REPLY, AU_MAP, AL_2, 1'b1,
                              input_status};
                diag_reply = 1'b0;
                state_next = ST_RUN;
            end
            // Diagnosis readout clears the UV and LOP latches; new events still win
            if (diag_reply) begin
                uv_next  = supply_undervoltage_event;
                lop_next = logic_supply_low_event;
            end
            // Soft reset answers at once with INPUT_STATUS_MONITOR and error flag
            if (soft_reset) begin
                resp_next  = {LEAD_REPLY, AU_MAP, AL_2, 1'b1,
                              input_status};
                ter_next   = 1'b1;
                uv_next    = 1'b1;
                lop_next   = 1'b1;
                fault_next = 8'h00;
                out_next   = OUT_RST;
                map0_next  = MAP0_RST;
                map1_next  = MAP1_RST;
                iol_next   = IOL_RST;
                hwcr_next  = HWCR_RST;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_d_reg  <= 1'b1;
            clr_reg   <= 1'b1;
            oe_n_reg  <= 1'b1;
            resp_reg  <= DIAG_RESET;
            state_reg <= ST_FRESH;
            ter_reg   <= 1'b1;
            uv_reg    <= 1'b1;
            lop_reg   <= 1'b1;
            mode_reg  <= MODE_IDLE;
            open_load_off_flag_reg <= 1'b0;
            fault_reg <= 8'h00;
            out_reg   <= OUT_RST;
            map0_reg  <= MAP0_RST;
            map1_reg  <= MAP1_RST;
            iol_reg   <= IOL_RST;
            hwcr_reg  <= HWCR_RST;
            ocl_reg   <= 8'h00;
        end else begin
            cs_d_reg  <= cs_d_next;
            clr_reg   <= clr_next;
            oe_n_reg  <= oe_n_next;
            resp_reg  <= resp_next;
            state_reg <= state_next;
            ter_reg   <= ter_next;
            uv_reg    <= uv_next;
            lop_reg   <= lop_next;
            mode_reg  <= mode_next;
            open_load_off_flag_reg <= open_load_off_flag_next;
            fault_reg <= fault_next;
            out_reg   <= out_next;
            map0_reg  <= map0_next;
            map1_reg  <= map1_next;
            iol_reg   <= iol_next;
            hwcr_reg  <= hwcr_next;
            ocl_reg   <= ocl_next;
        end
    end

    // ==========================================================
    // Register-driven outputs
    assign so_oe_n             = oe_n_reg;
    assign out_enable          = out_reg;
    assign map_in0             = map0_reg;
    assign map_in1             = map1_reg;
    assign diag_current_enable = iol_reg;
    assign hw_config           = hwcr_reg;
    assign latch_clear         = ocl_reg;

endmodule

/* sim/spi_master_model.sv */
// Bus master model for the SPI diagnosis block: frames and replies.
// Assumes sclk idles low and that no two frames overlap.
`timescale 1ns/100ps
module spi_master_model (
    output logic     sclk,
    output logic     cs_n,
    output logic     si,
    input wire logic so
);
    // ==========================================
    // Idle levels before the first frame
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // One frame of n clocks; the last 16 carry cmd
    task automatic xfer(input logic [15:0] cmd, input int n,
                        output logic [15:0] rsp);
        logic [31:0] w;
        w = {16'h0000, cmd};
        rsp = 16'h0000;
        cs_n = 1'b0;
        #200;
        for (int k = 0; k < n; k++) begin
            si = w[n - 1 - k];
            #3.75 sclk = 1'b1;
            #7.5 sclk = 1'b0;
            if (k < 16)
                rsp[15 - k] = so;
            #3.75;
        end
        #200 cs_n = 1'b1;
        si = ~si; // Released line shows no stale bit
        #260;
    endtask
endmodule

/* sim/spi_diag_asserts.sv */
// Port-level checks for the SPI diagnosis block.
// Assumes one sys_clk domain with synchronous active-low rst_n.
`timescale 1ns/100ps
module spi_diag_asserts (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       so_oe_n,
    input wire logic [7:0] out_enable,
    input wire logic [7:0] map_in0,
    input wire logic [7:0] map_in1,
    input wire logic [7:0] diag_current_enable,
    input wire logic [7:0] hw_config,
    input wire logic [7:0] latch_clear
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // ==========================================
    // Chip select phases
    sequence deselect_run;
        cs_n [*4];
    endsequence
    sequence select_run;
        (!cs_n) [*4];
    endsequence
    sequence frame_close;
        $rose(cs_n) ##1 cs_n;
    endsequence

    // ==========================================
    // Output enable and register timing
    oe_release_a: assert property (deselect_run |-> so_oe_n)
        else $error("so enabled while deselected");
    oe_drive_a: assert property (select_run |-> !so_oe_n)
        else $error("so not driven in frame");
    oe_bound_a: assert property (frame_close |-> ##[0:3] so_oe_n)
        else $error("so release too late");
    oe_enable_a: assert property ($fell(cs_n) |-> ##[1:4] !so_oe_n)
        else $error("so enable too late");
    clear_pulse_a: assert property (latch_clear != 8'h00 |=>
        latch_clear == 8'h00)
        else $error("clear pulse longer than one cycle");
    clear_timing_a: assert property (latch_clear != 8'h00 |->
        cs_n && $past(cs_n, 2))
        else $error("clear pulse inside a frame");
    regs_hold_a: assert property (!cs_n |=> $stable({out_enable,
        map_in0, map_in1, diag_current_enable, hw_config}))
        else $error("register changed inside a frame");
    reset_values_a: assert property ($rose(rst_n) |-> {out_enable,
        map_in0, map_in1, diag_current_enable, hw_config,
        latch_clear} == 48'h000408000000)
        else $error("register reset value wrong");
    soft_bit_a: assert property (!hw_config[6])
        else $error("self-clearing bit seen high");
endmodule

bind spi_frame_protocol_diag spi_diag_asserts chk (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .cs_n                (cs_n),
    .so_oe_n             (so_oe_n),
    .out_enable          (out_enable),
    .map_in0             (map_in0),
    .map_in1             (map_in1),
    .diag_current_enable (diag_current_enable),
    .hw_config           (hw_config),
    .latch_clear         (latch_clear)
);

/* sim/tb_spi_frame_protocol_diag.sv */
// Self-checking bench for the SPI frame protocol and diagnosis block.
// Assumes the master model in spi_master_model and a bound checker.
`timescale 1ns/100ps
module tb_spi_frame_protocol_diag;
    import spi_diag_pkg::*;
    logic        sys_clk, rst_n, sclk, cs_n, si, so_data, so_oe_n;
    logic        uv_ev, lop_ev, fresh, force_ev, exp_ok, m_uv, m_lop;
    logic [1:0]  mode;
    logic [6:0]  ins;
    logic [7:0]  cf, drain, m_out, m_m0, m_m1, m_iol, m_hw, m_err;
    logic [7:0]  lc_seen, exp_lc, out_en, map0, map1, dce, hwc, lc;
    logic [15:0] exp, mask, c;
    logic [31:0] seed, r;
    wire         so_wire;
    int          n_fail, checks;
    logic [5:0]  at [8] = '{6'h00, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09,
                            6'h0c, 6'h0d};
    int          nt [8] = '{8, 15, 17, 23, 24, 32, 16, 31};
    // Top byte: clock count; low 16 bits: command
    logic [23:0] ct [20] = '{24'h1080a5, 24'h100001, 24'h104002,
        24'h1088ff, 24'h088000, 24'h118000, 24'h178000, 24'h184002,
        24'h10c0ff, 24'h100002, 24'h1094ff, 24'h105402, 24'h104d02,
        24'h1086ff, 24'h108dff, 24'h204602, 24'h104902, 24'h108cc0,
        24'h104c02, 24'h100001};

    assign so_wire = so_oe_n ? 1'bz : so_data;

    spi_frame_protocol_diag dut (
        .sys_clk                   (sys_clk),
        .rst_n                     (rst_n),
        .sclk                      (sclk),
        .cs_n                      (cs_n),
        .si                        (si),
        .so_data                   (so_data),
        .so_oe_n                   (so_oe_n),
        .supply_undervoltage_event (uv_ev),
        .logic_supply_low_event    (lop_ev),
        .operating_mode            (mode),
        .channel_fault             (cf),
        .drain_below_threshold     (drain),
        .input_status              (ins),
        .out_enable                (out_en),
        .map_in0                   (map0),
        .map_in1                   (map1),
        .diag_current_enable       (dce),
        .hw_config                 (hwc),
        .latch_clear               (lc)
    );
    spi_master_model mdl (
        .sclk (sclk),
        .cs_n (cs_n),
        .si   (si),
        .so   (so_wire)
    );

    // ==========================================
    // Clock, watchdog and clear-pulse capture
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
    always @(posedge sys_clk)
        if (lc !== 8'h00)
            lc_seen <= lc;

    // ==========================================
    // Reference model
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 8; i++)
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic void sreset();
        {m_out, m_m0, m_m1, m_iol, m_hw} = 40'h0004080000;
        m_err = cf;
        {m_uv, m_lop, fresh} = 3'b111;
    endfunction
    function automatic logic [15:0] diag(input logic transfer_error_flag);
        diag = {1'b0, m_uv, m_lop, mode, transfer_error_flag, 1'b0,
                |(drain & m_iol & ~m_out), m_err};
        m_uv = 1'b0;
        m_lop = 1'b0;
    endfunction
    function automatic logic [15:0] predict(input logic [15:0] k, int n);
        logic [7:0] d;
        logic       rd;
        d = k[7:0];
        rd = 1'b1;
        mask = 16'hffff;
        exp_lc = 8'h00;
        if (n < 16 || n % 8 != 0)
            predict = diag(1'b1);
        else if (k[15:14] == 2'b10) begin
            predict = diag(1'b0);
            case (k[13:8])
                6'h00: m_out = d;
                6'h04: m_m0 = d;
                6'h05: m_m1 = d;
                6'h08: m_iol = d;
                6'h0c: begin
                    m_hw = d & 8'hbf;
                    if (d[6])
                        sreset();
                end
                6'h0d: begin
                    m_err = (m_err & ~d) | cf;
                    exp_lc = d;
                end
                default: ;
            endcase
        end else if (k[15:14] == 2'b01 && k[1:0] == 2'b10) begin
            case (k[13:8])
                6'h00: d = m_out;
                6'h04: d = m_m0;
                6'h05: d = m_m1;
                6'h06: d = {1'b0, ins};
                6'h08: d = m_iol;
                6'h09: d = drain;
                6'h0c: d = m_hw;
                default: rd = 1'b0;
            endcase
            predict = rd ? {2'b10, k[13:8], d} : diag(1'b0);
        end else
            predict = diag(1'b0);
        if (fresh) begin
            predict = {8'h86, 1'b1, ins};
            {m_uv, m_lop} = 2'b11;
        end
        force_ev = fresh;
        fresh = 1'b0;
    endfunction

    // ==========================================
    // Comparison, frame and closing tasks
    task automatic check(input string what, input logic [39:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [15:0] k, input int n);
        logic [31:0] v;
        logic [15:0] got, m;
        v = rnd();
        @(negedge sys_clk);
        mode = (v[1:0] == 2'b00) ? 2'b11 : v[1:0];
        drain = v[15:8];
        cf = v[23:16] & v[31:24] & {8{v[2]}};
        ins = v[30:24];
        uv_ev = force_ev | (v[4:3] == 2'b00);
        lop_ev = force_ev | (v[6:5] == 2'b00);
        m_err = m_err | cf;
        m_uv = m_uv | uv_ev;
        m_lop = m_lop | lop_ev;
        @(negedge sys_clk);
        uv_ev = 1'b0;
        lop_ev = 1'b0;
        mdl.xfer(k, n, got);
        m = (n < 16) ? ~(16'hffff >> n) : 16'hffff;
        if (exp_ok)
            check("reply", got & m & mask, exp & m & mask);
        exp = predict(k, n);
        exp_ok = 1'b1;
        check("regs", {out_en, map0, map1, dce, hwc},
              {m_out, m_m0, m_m1, m_iol, m_hw});
        check("clear", lc_seen, exp_lc);
        lc_seen = 8'h00;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Main sequence: corners, then random frames
    initial begin
        {rst_n, uv_ev, lop_ev, mode, ins, cf, drain} = '0;
        {n_fail, checks, exp_ok, force_ev, lc_seen} = '0;
        seed = 32'h0782;
        sreset();
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("oe", so_oe_n, 1'b1);
        foreach (ct[i])
            frame(ct[i][15:0], int'(ct[i][23:16]));
        repeat (80) begin
            r = rnd();
            c = r[31:16];
            case (r[2:0])
                3'h0: c[15:8] = {2'b10, at[r[5:3]]};
                3'h1: c = {2'b01, at[r[5:3]], c[7:2], 2'b10};
                3'h2: c = {1'b0, c[14:2], 2'b01};
                default: ;
            endcase
            frame(c, (r[8:6] == 3'h0) ? nt[r[11:9]] : 16);
        end
        report_and_stop();
    end
endmodule
